// ==== hdl/imst_top.sv ====
// Purpose: interrupt acknowledge and macro service timing engine on AHB-Lite
// Assumes: single 125 MHz clock hclk, zero-wait single word transfers
// Notes:   a start write runs priority resolution, then the computed latency
`include "imst_map.svh"
`timescale 1ns/1ns
`default_nettype none

module imst_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             fetch_start,
    output logic             vectored_req,
    output logic             busy
);
    import imst_pkg::*;

    // ------------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------------
    logic [7:0]  addr_q;
    logic        wr_q;
    logic [31:0] rdata_q;

    // only whole words are used; hsize is accepted but not checked
    wire        take     = hsel && htrans[1] && hready;
    wire        take_wr  = take && hwrite;
    wire        take_rd  = take && !hwrite;
    wire [2:0]  size_unused = hsize;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_q <= 8'h00;
            wr_q   <= 1'b0;
        end
        else
        begin
            // captured every cycle; only wr_q decides if it is used
            addr_q <= haddr[7:0];
            wr_q   <= take_wr;
        end
    end

    // ------------------------------------------------------------------
    // register write decode (data phase)
    // ------------------------------------------------------------------
    // writes land at the end of the data phase, while hwdata stands
    wire wr_ctrl   = wr_q && addr_q == `IMST_OFF_CTRL;
    wire wr_cfg    = wr_q && addr_q == `IMST_OFF_CFG;
    wire wr_wait   = wr_q && addr_q == `IMST_OFF_WAIT;
    wire wr_msc    = wr_q && addr_q == `IMST_OFF_MSC;
    wire wr_status = wr_q && addr_q == `IMST_OFF_STATUS;

    wire       start_req = wr_ctrl && hwdata[`IMST_CTRL_START];
    wire       ret_req   = wr_ctrl && hwdata[`IMST_CTRL_RETURN_FROM_INTERRUPT_OP];
    wire [2:0] op_field  = hwdata[`IMST_CTRL_OP_MSB:`IMST_CTRL_OP_LSB];

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    imst_cfg_t   cfg_q;
    imst_wait_t  wait_q;
    imst_op_t    op_q;
    logic [15:0] msc_q;
    logic [15:0] msc_d;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_q  <= imst_cfg_t'(`IMST_RST_CFG);
            wait_q <= imst_wait_t'(`IMST_RST_WAIT);
        end
        else
        begin
            // setup may change mid-run; latency is frozen at end of resolve
            if (wr_cfg)
                cfg_q <= imst_cfg_t'(hwdata[`IMST_CFG_MSB:0]);
            if (wr_wait)
                wait_q <= imst_wait_t'(hwdata[`IMST_WAIT_MSB:0]);
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    imst_state_t state_q;
    imst_state_t state_d;
    logic [7:0]  cnt_q;
    logic [7:0]  cnt_d;
    logic [7:0]  lat_q;
    logic [7:0]  lat_d;
    logic [7:0]  lat_calc;
    logic        lat_illegal;

    wire idle      = state_q == ST_IDLE;
    wire cnt_end   = cnt_q == 8'h00;
    wire is_macro  = op_q != OP_VECTORED && op_q != OP_CONTEXT_SWITCH;
    wire msc_hit   = msc_q == 16'h0001;
    wire begin_run = idle && start_req;
    wire res_done  = state_q == ST_RESOLVE && cnt_end;
    wire refuse    = res_done && !is_macro && lat_illegal;
    wire serve_end = state_q == ST_SERVE && cnt_end;
    wire ack_done  = serve_end && !is_macro;
    wire ms_zero   = serve_end && is_macro && msc_q == 16'h0000;

    imst_latency u_latency (
        .op       (op_q),
        .cfg      (cfg_q),
        .waits    (wait_q),
        .msc_zero (msc_hit),
        .latency  (lat_calc),
        .illegal  (lat_illegal)
    );

    // a start while busy is dropped; software polls busy first
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        lat_d   = lat_q;
        case (state_q)
            ST_IDLE:
            begin
                if (start_req)
                begin
                    state_d = ST_RESOLVE;
                    cnt_d   = `IMST_RESOLVE_CLKS - 8'd1;
                end
            end
            ST_RESOLVE:
            begin
                if (cnt_end)
                begin
                    if (refuse)
                        state_d = ST_IDLE;
                    else
                    begin
                        state_d = ST_SERVE;
                        lat_d   = lat_calc;
                        cnt_d   = lat_calc - 8'd1;
                    end
                end
                else
                    cnt_d = cnt_q - 8'd1;
            end
            ST_SERVE:
            begin
                if (cnt_end)
                    state_d = ST_IDLE;
                else
                    cnt_d = cnt_q - 8'd1;
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= 8'h00;
            lat_q   <= 8'h00;
            op_q    <= OP_VECTORED;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            lat_q   <= lat_d;
            // op latched at start, a later control write cannot alter a run
            if (begin_run)
                op_q <= imst_op_t'(op_field);
        end
    end

    // ------------------------------------------------------------------
    // macro service counter
    // ------------------------------------------------------------------
    // decremented when the service is committed; a zero count does not wrap
    // latency sees the count before this step: one means it reaches zero
    always_comb
    begin
        msc_d = msc_q;
        if (wr_msc)
            msc_d = hwdata[`IMST_MSC_MSB:0];
        else if (res_done && is_macro && msc_q != 16'h0000)
            msc_d = msc_q - 16'h0001;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            msc_q <= `IMST_RST_MSC;
        else
            msc_q <= msc_d;
    end

    // ------------------------------------------------------------------
    // in-service priority record
    // ------------------------------------------------------------------
    logic [7:0] in_service_priority_reg;
    // a refused context switch never completes, so no level is recorded

    imst_prio u_prio (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .set_en    (ack_done),
        .set_level (cfg_q.level),
        .ret_en    (ret_req),
        .in_service_priority_reg_q    (in_service_priority_reg)
    );

    // ------------------------------------------------------------------
    // sticky status, write one to clear, a new event wins
    // ------------------------------------------------------------------
    // busy bit is live; done, illegal and request stay until cleared
    logic done_q;
    logic illegal_q;
    logic vecreq_q;

    wire clr_done    = wr_status && hwdata[`IMST_ST_DONE];
    wire clr_illegal = wr_status && hwdata[`IMST_ST_ILLEGAL];
    wire clr_vecreq  = wr_status && hwdata[`IMST_ST_VECREQ];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            done_q    <= 1'b0;
            illegal_q <= 1'b0;
            vecreq_q  <= 1'b0;
        end
        else
        begin
            done_q    <= serve_end || (done_q && !clr_done);
            illegal_q <= refuse || (illegal_q && !clr_illegal);
            vecreq_q  <= ms_zero || (vecreq_q && !clr_vecreq);
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fetch_start  <= 1'b0;
            vectored_req <= 1'b0;
            busy         <= 1'b0;
        end
        else
        begin
            // one-cycle pulses; a consumer must latch them
            fetch_start  <= ack_done;
            vectored_req <= ms_zero;
            // follows the next state, so it rises right after the start edge
            busy         <= state_d != ST_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // read data, prepared in the address phase so hrdata is a flop
    // ------------------------------------------------------------------
    wire [31:0] status_word = {28'h000_0000, vecreq_q, illegal_q, done_q, !idle};
    wire [7:0]  raddr       = haddr[7:0];
    // read decode; unmapped offsets read zero
    wire        rd_ctrl     = raddr == `IMST_OFF_CTRL;
    wire        rd_cfg      = raddr == `IMST_OFF_CFG;
    wire        rd_wait     = raddr == `IMST_OFF_WAIT;
    wire        rd_msc      = raddr == `IMST_OFF_MSC;
    wire        rd_status   = raddr == `IMST_OFF_STATUS;
    wire        rd_latency  = raddr == `IMST_OFF_LATENCY;
    wire        rd_in_service_priority_reg     = raddr == `IMST_OFF_IN_SERVICE_PRIORITY_REG;

    wire [31:0] rmux =
        rd_ctrl    ? {28'h000_0000, 1'b0, op_q} :
        rd_cfg     ? {15'h0000, cfg_q} :
        rd_wait    ? {12'h000, wait_q} :
        rd_msc     ? {16'h0000, msc_q} :
        rd_status  ? status_word :
        rd_latency ? {24'h00_0000, lat_q} :
        rd_in_service_priority_reg    ? {24'h00_0000, in_service_priority_reg} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rdata_q   <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            if (take_rd)
                rdata_q <= rmux;
            // zero-wait slave: no stall path exists
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata = rdata_q;

endmodule

`default_nettype wire

// ==== shared/imst_map.svh ====
// Purpose: register offsets, field positions, reset values and clock counts
// Assumes: 32-bit word registers on the bus, all counts in system clocks
// Notes:   definitions only
`ifndef IMST_MAP_SVH
`define IMST_MAP_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses, low byte compared)
// ----------------------------------------------------------------------
`define IMST_OFF_CTRL        8'h00
`define IMST_OFF_CFG         8'h04
`define IMST_OFF_WAIT        8'h08
`define IMST_OFF_MSC         8'h0C
`define IMST_OFF_STATUS      8'h10
`define IMST_OFF_LATENCY     8'h14
`define IMST_OFF_IN_SERVICE_PRIORITY_REG        8'h18

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define IMST_CTRL_START      0
`define IMST_CTRL_OP_LSB     1
`define IMST_CTRL_OP_MSB     3
`define IMST_CTRL_RETURN_FROM_INTERRUPT_OP       4
`define IMST_ST_BUSY         0
`define IMST_ST_DONE         1
`define IMST_ST_ILLEGAL      2
`define IMST_ST_VECREQ       3
`define IMST_CFG_MSB         16
`define IMST_WAIT_MSB        19
`define IMST_MSC_MSB         15
`define IMST_RST_CFG         17'h0_0000
`define IMST_RST_WAIT        20'h0_0000
`define IMST_RST_MSC         16'h0000

// ----------------------------------------------------------------------
// clock counts
// ----------------------------------------------------------------------
`define IMST_RESOLVE_CLKS    8'd8
`define IMST_VEC_FAST_INTERNAL_RAM        8'd26
`define IMST_VEC_PERIPHERAL_RAM        8'd29
`define IMST_VEC_SLOW        8'd37
`define IMST_VEC_TBL_SLOW    8'd4
`define IMST_BRANCH_SLOW     8'd1
`define IMST_STACK_WRITES    8'd4
`define IMST_ODD_SP_ADD      8'd4
`define IMST_CTX_BASE        8'd22
`define IMST_MS_A_1          8'd24
`define IMST_MS_A_2_TO_MEM   8'd25
`define IMST_MS_A_2_TO_SFR   8'd26
`define IMST_MS_B_FAST       8'd33
`define IMST_MS_B_SLOW       8'd35
`define IMST_MS_C_FAST       8'd49
`define IMST_MS_C_SLOW       8'd53
`define IMST_MS_CNT_NZ       8'd17
`define IMST_MS_CNT_Z        8'd25
`define IMST_ODD_DATA_ADD    8'd4
`define IMST_TWO_BYTE_SLOW   8'd4
`define IMST_MSC_ZERO_ADD    8'd1
`define IMST_RING_ADD        8'd4
`define IMST_RING_ZERO_ADD   8'd7

`endif

// ==== shared/imst_pkg.sv ====
// Purpose: types shared by the timing block
// Assumes: nothing
// Notes:   field order of the structs matches the register bit layout
`default_nettype none

package imst_pkg;

    typedef enum logic [1:0] {
        LOC_FAST_INTERNAL_ROM,
        LOC_FAST_INTERNAL_RAM,
        LOC_PERIPHERAL_RAM,
        LOC_SLOW_OR_EXTERNAL_MEMORY
    } imst_loc_t;

    typedef enum logic [2:0] {
        OP_VECTORED,
        OP_CONTEXT_SWITCH,
        OP_MACRO_A,
        OP_MACRO_B,
        OP_MACRO_C,
        OP_MACRO_COUNTER
    } imst_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RESOLVE,
        ST_SERVE
    } imst_state_t;

    typedef struct packed {
        logic [2:0] level;
        logic       ring_zero;
        logic       ring_en;
        logic       data_odd;
        logic       sp_odd;
        logic       mem_to_sfr;
        logic       two_byte;
        imst_loc_t  data_loc;
        imst_loc_t  stack_loc;
        imst_loc_t  branch_loc;
        imst_loc_t  vector_loc;
    } imst_cfg_t;

    typedef struct packed {
        logic [3:0] data_wait;
        logic [3:0] fetch_wait;
        logic [3:0] vector_wait;
        logic [3:0] access_wait;
        logic [3:0] addr_wait;
    } imst_wait_t;

endpackage

`default_nettype wire

// ==== hdl/imst_latency.sv ====
// Purpose: latency of one acknowledgment or macro service, in clocks
// Assumes: configuration stable while the result is sampled
// Notes:   purely combinational
`include "imst_map.svh"
`timescale 1ns/1ns
`default_nettype none

module imst_latency (
    input  wire imst_pkg::imst_op_t   op,
    input  wire imst_pkg::imst_cfg_t  cfg,
    input  wire imst_pkg::imst_wait_t waits,
    input  wire logic                 msc_zero,
    output logic [7:0]                latency,
    output logic                      illegal
);
    import imst_pkg::*;

    wire [7:0] stack_n  = {4'h0, waits.addr_wait} + {4'h0, waits.access_wait};
    wire [7:0] vec_m    = {4'h0, waits.vector_wait};
    wire [7:0] fetch_w  = {4'h0, waits.fetch_wait};
    wire [7:0] data_n   = {4'h0, waits.data_wait};
    wire       vec_slow = cfg.vector_loc == LOC_SLOW_OR_EXTERNAL_MEMORY;
    wire       br_slow  = cfg.branch_loc == LOC_SLOW_OR_EXTERNAL_MEMORY;
    wire       dat_fast = cfg.data_loc == LOC_FAST_INTERNAL_RAM;
    wire       dat_slow = cfg.data_loc == LOC_SLOW_OR_EXTERNAL_MEMORY;
    wire       dat_int  = dat_fast || cfg.data_loc == LOC_FAST_INTERNAL_ROM;

    always_comb
    begin
        latency = 8'h00;
        illegal = 1'b0;
        case (op)
            OP_VECTORED:
            begin
                case (cfg.stack_loc)
                    LOC_PERIPHERAL_RAM:          latency = `IMST_VEC_PERIPHERAL_RAM;
                    LOC_SLOW_OR_EXTERNAL_MEMORY:
                        latency = `IMST_VEC_SLOW + stack_n * `IMST_STACK_WRITES;
                    default:                     latency = `IMST_VEC_FAST_INTERNAL_RAM;
                endcase
                if (vec_slow)
                    latency = latency + `IMST_VEC_TBL_SLOW + (vec_m << 1);
                if (br_slow)
                    latency = latency + `IMST_BRANCH_SLOW + fetch_w;
                if (cfg.stack_loc == LOC_PERIPHERAL_RAM && cfg.sp_odd)
                    latency = latency + `IMST_ODD_SP_ADD;
            end
            OP_CONTEXT_SWITCH:
            begin
                // only a fast internal-ram stack may take a context switch
                illegal = cfg.stack_loc != LOC_FAST_INTERNAL_RAM;
                latency = `IMST_CTX_BASE;
                if (br_slow)
                    latency = latency + `IMST_BRANCH_SLOW + fetch_w;
                if (vec_slow)
                    latency = latency + vec_m;
            end
            OP_MACRO_COUNTER:
                latency = msc_zero ? `IMST_MS_CNT_Z : `IMST_MS_CNT_NZ;
            default:
            begin
                case (op)
                    OP_MACRO_A:
                        latency = !cfg.two_byte ? `IMST_MS_A_1 :
                                  cfg.mem_to_sfr ? `IMST_MS_A_2_TO_SFR
                                                 : `IMST_MS_A_2_TO_MEM;
                    OP_MACRO_B:
                        latency = (dat_fast ? `IMST_MS_B_FAST : `IMST_MS_B_SLOW)
                                  + {7'h00, cfg.mem_to_sfr};
                    default:
                        latency = dat_fast ? `IMST_MS_C_FAST : `IMST_MS_C_SLOW;
                endcase
                if (cfg.two_byte && dat_int && cfg.data_odd)
                    latency = latency + `IMST_ODD_DATA_ADD;
                if (dat_slow)
                    latency = latency + (cfg.two_byte
                              ? `IMST_TWO_BYTE_SLOW + (data_n << 1) : data_n);
                if (msc_zero)
                    latency = latency + `IMST_MSC_ZERO_ADD;
                if (op == OP_MACRO_C && cfg.ring_en)
                    latency = latency + `IMST_RING_ADD
                              + (cfg.ring_zero ? `IMST_RING_ZERO_ADD : 8'h00);
            end
        endcase
    end

endmodule

`default_nettype wire

// ==== hdl/imst_prio.sv ====
// Purpose: in-service priority record of acknowledged levels
// Assumes: level 0 is the highest priority
// Notes:   cleared as a whole only by the reset input; a return clears one level
`timescale 1ns/1ns
`default_nettype none

module imst_prio (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       set_en,
    input  wire logic [2:0] set_level,
    input  wire logic       ret_en,
    output logic [7:0]      in_service_priority_reg_q
);
    // lowest set bit is the routine currently running
    wire [7:0] running   = in_service_priority_reg_q & (~in_service_priority_reg_q + 8'h01);
    wire [7:0] clear_msk = ret_en ? running : 8'h00;
    wire [7:0] set_msk   = set_en ? (8'h01 << set_level) : 8'h00;
    // a new level taken in the same cycle as a return survives it
    wire [7:0] in_service_priority_reg_d    = (in_service_priority_reg_q & ~clear_msk) | set_msk;

    // no soft clear exists on purpose: only hresetn brings it back
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            in_service_priority_reg_q <= 8'h00;
        else
            in_service_priority_reg_q <= in_service_priority_reg_d;
    end

endmodule

`default_nettype wire

// ==== testbench/imst_top_asserts.sv ====
// Purpose: port timing checks for imst_top
// Assumes: one clock, reset active low
// Notes:   bound below the module
`timescale 1ns/1ns
`default_nettype none

module imst_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fetch_start,
    input wire logic vectored_req,
    input wire logic busy
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_resolve;
        busy [*8];
    endsequence
    // shortest acknowledge is 8 resolve plus 22 serve clocks
    sequence s_no_fetch;
        !fetch_start throughout (1'b1 ##28 1'b1);
    endsequence
    // shortest macro service is 8 plus 17 clocks
    sequence s_no_vreq;
        !vectored_req throughout (1'b1 ##20 1'b1);
    endsequence

    property p_resolve; $rose(busy) |-> s_resolve; endproperty
    property p_early_fetch; $rose(busy) |-> s_no_fetch; endproperty
    property p_early_vreq; $rose(busy) |-> s_no_vreq; endproperty
    property p_fetch_pulse; fetch_start |=> !fetch_start; endproperty
    property p_vreq_pulse; vectored_req |=> !vectored_req; endproperty
    property p_fetch_cause; fetch_start |-> $past(busy, 2); endproperty
    property p_vreq_cause; vectored_req |-> $past(busy, 2); endproperty
    property p_exclusive; fetch_start |-> !vectored_req; endproperty

    a_resolve: assert property (p_resolve)
        else $error("resolve too short");
    a_early_fetch: assert property (p_early_fetch)
        else $error("fetch too early");
    a_early_vreq: assert property (p_early_vreq)
        else $error("request too early");
    a_fetch_pulse: assert property (p_fetch_pulse)
        else $error("fetch pulse too long");
    a_vreq_pulse: assert property (p_vreq_pulse)
        else $error("request pulse too long");
    a_fetch_cause: assert property (p_fetch_cause)
        else $error("fetch while idle");
    a_vreq_cause: assert property (p_vreq_cause)
        else $error("request while idle");
    a_exclusive: assert property (p_exclusive)
        else $error("fetch and request together");
endmodule

bind imst_top imst_asserts u_chk (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .fetch_start  (fetch_start),
    .vectored_req (vectored_req),
    .busy         (busy)
);

`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for imst_top
// Assumes: single slave, hready fed from hreadyout
// Notes:   serve times compared against resolve plus latency
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        fetch_start;
    logic        vectored_req;
    logic        busy;
    int          fails = 0;
    int          checked = 0;

    always #4 hclk = ~hclk;

    imst_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .fetch_start(fetch_start), .vectored_req(vectored_req), .busy(busy)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rc(input logic [2:0] op, input logic [19:0] c, input logic [19:0] w,
                      input logic [15:0] m, input logic [7:0] lat, input logic [1:0] ev);
        logic [31:0] rd;
        int          n;
        int          k;
        logic        f;
        logic        v;
        ahb(1'b1, 8'h04, {12'h000, c}, rd);
        ahb(1'b1, 8'h08, {12'h000, w}, rd);
        ahb(1'b1, 8'h0C, {16'h0000, m}, rd);
        ahb(1'b1, 8'h00, {28'h000_0000, op, 1'b1}, rd);
        n = 0;
        k = 0;
        f = 1'b0;
        v = 1'b0;
        // run on a little past busy so a trailing pulse is still seen
        while (k < 3 || n < 4)
        begin
            @(negedge hclk);
            n++;
            k = (busy === 1'b1) ? 0 : k + 1;
            f |= (fetch_start === 1'b1);
            v |= (vectored_req === 1'b1);
        end
        check({30'h0, v, f}, {30'h0, ev});
        if (lat != 8'h00)
        begin
            // 8 resolve cycles, the latency, then 3 idle polls
            check(32'(n), 32'(lat) + 32'd11);
            ahb(1'b0, 8'h14, 32'h0000_0000, rd);
            check(rd, {24'h00_0000, lat});
        end
        if (op > 3'h1)
        begin
            ahb(1'b0, 8'h0C, 32'h0000_0000, rd);
            check(rd, {16'h0000, m - 16'h0001});
        end
    endtask

    task automatic test_vectored();
        rc(3'h0, 20'h0_0010, 20'h0_0000, 16'h0000, 8'h1A, 2'b01);
        rc(3'h0, 20'h0_0020, 20'h0_0000, 16'h0000, 8'h1D, 2'b01);
        rc(3'h0, 20'h0_0030, 20'h0_0021, 16'h0000, 8'h31, 2'b01);
        rc(3'h0, 20'h0_001C, 20'h0_2000, 16'h0000, 8'h1D, 2'b01);
        rc(3'h0, 20'h0_0023, 20'h0_0100, 16'h0000, 8'h23, 2'b01);
        rc(3'h0, 20'h0_003F, 20'h0_0201, 16'h0000, 8'h32, 2'b01);
        rc(3'h0, 20'h0_0420, 20'h0_0000, 16'h0000, 8'h21, 2'b01);
        $display("test_vectored done");
    endtask

    task automatic test_context();
        logic [31:0] rd;
        rc(3'h1, 20'h0_0010, 20'h0_0000, 16'h0000, 8'h16, 2'b01);
        rc(3'h1, 20'h0_0018, 20'h0_0000, 16'h0000, 8'h16, 2'b01);
        rc(3'h1, 20'h0_001F, 20'h0_1300, 16'h0000, 8'h1B, 2'b01);
        rc(3'h1, 20'h0_0020, 20'h0_0000, 16'h0000, 8'h00, 2'b00);
        ahb(1'b0, 8'h10, 32'h0000_0000, rd);
        check(rd & 32'h0000_0004, 32'h0000_0004);
        $display("test_context done");
    endtask

    task automatic test_macro();
        rc(3'h2, 20'h0_0040, 20'h0_0000, 16'h0005, 8'h18, 2'b00);
        rc(3'h2, 20'h0_0140, 20'h0_0000, 16'h0005, 8'h19, 2'b00);
        rc(3'h2, 20'h0_0340, 20'h0_0000, 16'h0005, 8'h1A, 2'b00);
        rc(3'h2, 20'h0_0940, 20'h0_0000, 16'h0005, 8'h1D, 2'b00);
        rc(3'h2, 20'h0_00C0, 20'h3_0000, 16'h0005, 8'h1B, 2'b00);
        rc(3'h2, 20'h0_01C0, 20'h2_0000, 16'h0005, 8'h21, 2'b00);
        rc(3'h3, 20'h0_0040, 20'h0_0000, 16'h0005, 8'h21, 2'b00);
        rc(3'h3, 20'h0_0240, 20'h0_0000, 16'h0005, 8'h22, 2'b00);
        rc(3'h3, 20'h0_00C0, 20'h0_0000, 16'h0005, 8'h23, 2'b00);
        rc(3'h3, 20'h0_02C0, 20'h0_0000, 16'h0005, 8'h24, 2'b00);
        rc(3'h4, 20'h0_0040, 20'h0_0000, 16'h0005, 8'h31, 2'b00);
        rc(3'h4, 20'h0_00C0, 20'h0_0000, 16'h0005, 8'h35, 2'b00);
        rc(3'h4, 20'h0_1040, 20'h0_0000, 16'h0005, 8'h35, 2'b00);
        rc(3'h4, 20'h0_3040, 20'h0_0000, 16'h0005, 8'h3C, 2'b00);
        rc(3'h5, 20'h0_0000, 20'h0_0000, 16'h0005, 8'h11, 2'b00);
        rc(3'h5, 20'h0_0000, 20'h0_0000, 16'h0001, 8'h19, 2'b10);
        rc(3'h2, 20'h0_0040, 20'h0_0000, 16'h0001, 8'h19, 2'b10);
        rc(3'h4, 20'h0_0040, 20'h0_0000, 16'h0001, 8'h32, 2'b10);
        $display("test_macro done");
    endtask

    task automatic test_restore();
        logic [31:0] rd;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 8'h18, 32'h0000_0000, rd);
        check(rd, 32'h0000_0000);
        rc(3'h0, 20'h1_4010, 20'h0_0000, 16'h0000, 8'h1A, 2'b01);
        rc(3'h0, 20'h0_8010, 20'h0_0000, 16'h0000, 8'h1A, 2'b01);
        // the record is read-only, a write must leave it alone
        ahb(1'b1, 8'h18, 32'h0000_00FF, rd);
        ahb(1'b0, 8'h18, 32'h0000_0000, rd);
        check(rd, 32'h0000_0024);
        check({31'h0, busy}, 32'h0000_0000);
        ahb(1'b1, 8'h00, 32'h0000_0010, rd);
        ahb(1'b0, 8'h18, 32'h0000_0000, rd);
        check(rd, 32'h0000_0020);
        ahb(1'b1, 8'h10, 32'h0000_000E, rd);
        ahb(1'b0, 8'h10, 32'h0000_0000, rd);
        check(rd, 32'h0000_0000);
        ahb(1'b0, 8'hFC, 32'h0000_0000, rd);
        check(rd, 32'h0000_0000);
        check({31'h0, hresp}, 32'h0000_0000);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 8'h18, 32'h0000_0000, rd);
        check(rd, 32'h0000_0000);
        $display("test_restore done");
    endtask

    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #200000;
        fails++;
        print_verdict();
    end

    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        test_vectored();
        test_context();
        test_macro();
        test_restore();
        print_verdict();
    end
endmodule

`default_nettype wire
